// file: include/rxd_pkg.sv
// Package with register map, field layout and timing constants of the receive ring block
package rxd_pkg;
  // Register byte offsets
  localparam logic [15:0] RXD_OFS_RING_SIZE = 16'h2808;
  localparam logic [15:0] RXD_OFS_RING_HEAD = 16'h2810;
  localparam logic [15:0] RXD_OFS_RING_TAIL = 16'h2818;
  localparam logic [15:0] RXD_OFS_PKT_DELAY = 16'h2820;
  localparam logic [15:0] RXD_OFS_ABS_DELAY = 16'h282C;
  // Ring size field position (descriptor_count_field)
  localparam int RXD_SIZE_LSB = 7;
  localparam int RXD_SIZE_MSB = 19;
  localparam int RXD_SIZE_W = RXD_SIZE_MSB - RXD_SIZE_LSB + 1;
  // Descriptor size is 16 bytes, so index = bytes >> 4
  localparam int RXD_DESC_SHIFT = 4;
  // Index and timer field width
  localparam int RXD_IDX_W = 16;
  localparam int RXD_TMR_W = 16;
  // Flush bit of the packet delay register
  localparam int RXD_FLUSH_BIT = 31;
  // Reset values
  localparam logic [RXD_SIZE_W-1:0] RXD_RST_SIZE = 13'h0000;
  localparam logic [RXD_IDX_W-1:0] RXD_RST_IDX = 16'h0000;
  localparam logic [RXD_TMR_W-1:0] RXD_RST_TMR = 16'h0000;
  // Timer tick of 1.024 us, clock period of 8 ns, both in picoseconds
  localparam int RXD_TICK_PS = 1_024_000;
  localparam int RXD_CLK_PS = 8_000;
  localparam int RXD_TICK_CYCLES = RXD_TICK_PS / RXD_CLK_PS;
  localparam int RXD_PRESC_W = $clog2(RXD_TICK_CYCLES);
  localparam logic [RXD_PRESC_W-1:0] RXD_PRESC_LAST = RXD_PRESC_W'(RXD_TICK_CYCLES - 1);
  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rxd_reg_req_t;
  // Countdown timer state
  typedef struct packed {
    logic run;
    logic [RXD_TMR_W-1:0] cnt;
  } rxd_timer_t;
endpackage

// file: hw/rxd_ring_timer.sv
// Receive descriptor ring bookkeeping and receive interrupt delay timers
`timescale 1ns/10ps
module rxd_ring_timer
  import rxd_pkg::*;
#(
  parameter int TICK_CYCLES = RXD_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire rxd_reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Receiver control
  input wire logic rx_enable_i,
  input wire logic rx_reset_i,
  // Receive datapath events
  input wire logic desc_take_i,
  input wire logic pkt_done_i,
  // Ring status
  output logic desc_grant_o,
  output logic [RXD_IDX_W-1:0] ring_head_o,
  output logic ring_empty_o,
  // Timer outcomes
  output logic flush_o,
  output logic rx_timer_irq_o
);

  // Prescaler width follows the tick length
  // A tick of one cycle still needs a one-bit counter
  // Simulation shortens the tick so that timers expire quickly
  // Prescaler runs free from reset and is never restarted
  // So the first tick after a load comes at any phase
  // Hence a count N expires between N-1 and N ticks later
  // Software must allow for that one-tick jitter
  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PLAST = PW'(TICK_CYCLES - 1);

  // Whole block state
  // Ring geometry and pointers come first
  // Programmed delay values are kept apart from the live counts
  // Live counts reload from the programmed values on every expiry
  // Read data is held here for exactly one cycle
  // Grant, flush and interrupt are one-cycle pulses
  // Empty is recomputed from the next head and tail
  // Every output of the block is taken from this record
  // Nothing outside this record holds state
  // Reset values of every field are given in the state register
  typedef struct packed {
    logic [RXD_SIZE_W-1:0] size;
    logic [RXD_IDX_W-1:0] head;
    logic [RXD_IDX_W-1:0] tail;
    logic [RXD_TMR_W-1:0] pkt_val;
    logic [RXD_TMR_W-1:0] abs_val;
    rxd_timer_t pkt_tmr;
    rxd_timer_t abs_tmr;
    logic [PW-1:0] presc;
    logic [31:0] rdata;
    logic grant;
    logic empty;
    logic flush;
    logic irq;
  } rxd_state_t;

  // Register and its next value
  rxd_state_t st_r;
  rxd_state_t st_nxt;

  // Number of 16-byte descriptors in the ring
  function automatic logic [RXD_IDX_W-1:0] ring_descs(input logic [RXD_SIZE_W-1:0] size);
    logic [31:0] bytes;
    bytes = 32'(size) << RXD_SIZE_LSB;
    return bytes[RXD_IDX_W+RXD_DESC_SHIFT-1:RXD_DESC_SHIFT];
  endfunction

  // Timer step on a tick: count down, hold at zero
  function automatic rxd_timer_t tmr_step(input rxd_timer_t t, input logic tick);
    rxd_timer_t n;
    n = t;
    if (t.run && tick && (t.cnt != RXD_RST_TMR))
    begin
      n.cnt = t.cnt - 16'h0001;
    end
    return n;
  endfunction

  // Timer expiry: running and last tick of the count
  function automatic logic tmr_done(input rxd_timer_t t, input logic tick);
    return t.run && tick && (t.cnt == 16'h0001);
  endfunction

  // Next-state logic
  // Order of the blocks below matters
  // Register writes come first so that events may override them
  // Descriptor consumption then moves the head
  // Timers step next, then packet events reload them
  // Any expiry reloads and halts both timers
  // Packet or forced expiry wins over an absolute expiry
  // Only one pulse leaves the block for a double expiry
  // A packet in the cycle of its own expiry restarts the count
  // A zero absolute value keeps the absolute timer stopped
  // Receiver reset is last and overrides all events of the cycle
  // Receiver reset keeps the programmed size and delays
  // Head writes while enabled are not blocked here
  // Keeping the head stable is a duty of the host driver
  // Reads show the state before any write of the same cycle
  // Unmapped addresses read zero and ignore writes
  // Head never passes the tail, equal means nothing free
  // Wrap is taken at the ring end derived from the size field
  // A size of zero keeps the head at zero
  // Forced expiry bit is never stored, so it reads zero
  // Reserved upper bits are dropped on every write
  always_comb
  begin
    logic tick;
    logic pkt_exp;
    logic abs_exp;
    logic force_exp;
    logic [RXD_IDX_W-1:0] descs;
    logic [RXD_IDX_W-1:0] head_inc;
    tick = 1'b0;
    pkt_exp = 1'b0;
    abs_exp = 1'b0;
    force_exp = 1'b0;
    descs = ring_descs(st_r.size);
    head_inc = st_r.head + 16'h0001;
    st_nxt = st_r;
    st_nxt.grant = 1'b0;
    st_nxt.flush = 1'b0;
    st_nxt.irq = 1'b0;
    st_nxt.rdata = 32'h0000_0000;

    // Tick prescaler, one pulse per 1.024 us
    if (st_r.presc == PLAST)
    begin
      st_nxt.presc = '0;
      tick = 1'b1;
    end
    else
    begin
      st_nxt.presc = st_r.presc + PW'(1);
    end

    // Register writes
    if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        RXD_OFS_RING_SIZE:
        begin
          // Low seven bits dropped, upper bits reserved
          st_nxt.size = reg_req_i.wdata[RXD_SIZE_MSB:RXD_SIZE_LSB];
        end
        RXD_OFS_RING_HEAD:
        begin
          // Only safe while receiver is stopped
          st_nxt.head = reg_req_i.wdata[RXD_IDX_W-1:0];
        end
        RXD_OFS_RING_TAIL:
        begin
          st_nxt.tail = reg_req_i.wdata[RXD_IDX_W-1:0];
        end
        RXD_OFS_PKT_DELAY:
        begin
          st_nxt.pkt_val = reg_req_i.wdata[RXD_TMR_W-1:0];
          force_exp = reg_req_i.wdata[RXD_FLUSH_BIT];
        end
        RXD_OFS_ABS_DELAY:
        begin
          st_nxt.abs_val = reg_req_i.wdata[RXD_TMR_W-1:0];
        end
        default:
        begin
          // Unmapped write ignored
        end
      endcase
    end

    // Register reads, data shown in the following cycle
    if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        RXD_OFS_RING_SIZE: st_nxt.rdata = 32'(st_r.size) << RXD_SIZE_LSB;
        RXD_OFS_RING_HEAD: st_nxt.rdata = 32'(st_r.head);
        RXD_OFS_RING_TAIL: st_nxt.rdata = 32'(st_r.tail);
        RXD_OFS_PKT_DELAY: st_nxt.rdata = 32'(st_r.pkt_val);
        RXD_OFS_ABS_DELAY: st_nxt.rdata = 32'(st_r.abs_val);
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Descriptor consumption, never past the tail
    if (desc_take_i && rx_enable_i && (st_r.head != st_r.tail))
    begin
      st_nxt.grant = 1'b1;
      // Wrap to zero at ring end
      if (head_inc >= descs)
      begin
        st_nxt.head = RXD_RST_IDX;
      end
      else
      begin
        st_nxt.head = head_inc;
      end
    end

    // Countdown both timers
    st_nxt.pkt_tmr = tmr_step(st_r.pkt_tmr, tick);
    st_nxt.abs_tmr = tmr_step(st_r.abs_tmr, tick);
    pkt_exp = tmr_done(st_r.pkt_tmr, tick);
    abs_exp = tmr_done(st_r.abs_tmr, tick) && (st_r.abs_val != RXD_RST_TMR);

    // Packet written to host memory
    if (pkt_done_i)
    begin
      if (st_r.pkt_val == RXD_RST_TMR)
      begin
        // No delay: interrupt at once
        pkt_exp = 1'b1;
        st_nxt.pkt_tmr.run = 1'b0;
      end
      else
      begin
        // Reload and restart on every packet
        st_nxt.pkt_tmr.cnt = st_r.pkt_val;
        st_nxt.pkt_tmr.run = 1'b1;
        pkt_exp = 1'b0;
      end
      // Absolute count starts on the first packet only
      if ((st_r.abs_val != RXD_RST_TMR) && !st_r.abs_tmr.run && !abs_exp)
      begin
        st_nxt.abs_tmr.cnt = st_r.abs_val;
        st_nxt.abs_tmr.run = 1'b1;
      end
    end

    // Packet delay or forced expiry cancels the absolute timer
    if (pkt_exp || force_exp)
    begin
      st_nxt.flush = 1'b1;
      st_nxt.irq = 1'b1;
      st_nxt.pkt_tmr.run = 1'b0;
      st_nxt.pkt_tmr.cnt = st_r.pkt_val;
      st_nxt.abs_tmr.run = 1'b0;
      st_nxt.abs_tmr.cnt = st_r.abs_val;
    end
    else if (abs_exp)
    begin
      // Absolute expiry cancels the packet delay
      st_nxt.flush = 1'b1;
      st_nxt.irq = 1'b1;
      st_nxt.abs_tmr.run = 1'b0;
      st_nxt.abs_tmr.cnt = st_r.abs_val;
      st_nxt.pkt_tmr.run = 1'b0;
      st_nxt.pkt_tmr.cnt = st_r.pkt_val;
    end

    // Disabled absolute timer never runs
    if (st_nxt.abs_val == RXD_RST_TMR)
    begin
      st_nxt.abs_tmr.run = 1'b0;
    end

    // Receiver reset clears pointers and stops timers
    if (rx_reset_i)
    begin
      st_nxt.head = RXD_RST_IDX;
      st_nxt.tail = RXD_RST_IDX;
      st_nxt.pkt_tmr = '0;
      st_nxt.abs_tmr = '0;
      st_nxt.grant = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.irq = 1'b0;
    end

    // Head equal to tail means nothing free
    st_nxt.empty = (st_nxt.head == st_nxt.tail);
  end

  // State register
  // Asynchronous reset loads constants only
  // Empty starts high since head and tail both start at zero
  // Prescaler restarts its phase at reset
  // Pulses are low during and after reset
  // Read data is zero until the first read
  // Timers are stopped with zero counts
  // Programmed values start at zero, so both timers idle
  // Zero packet delay means one pulse per packet
  // Zero absolute delay means absolute timer off
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '{size: RXD_RST_SIZE, head: RXD_RST_IDX, tail: RXD_RST_IDX,
                pkt_val: RXD_RST_TMR, abs_val: RXD_RST_TMR, pkt_tmr: '0,
                abs_tmr: '0, presc: '0, rdata: 32'h0000_0000, grant: 1'b0,
                empty: 1'b1, flush: 1'b0, irq: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  // No logic sits between a flip-flop and a pin
  // Flush and interrupt always rise together
  // Grant rises with the head step it reports
  // Read data stands only in the cycle after the read strobe
  // Head output lets the datapath address the next descriptor
  // Empty output lets the datapath hold off its requests
  assign reg_rdata_o = st_r.rdata;
  assign desc_grant_o = st_r.grant;
  assign ring_head_o = st_r.head;
  assign ring_empty_o = st_r.empty;
  assign flush_o = st_r.flush;
  assign rx_timer_irq_o = st_r.irq;

endmodule // rxd_ring_timer

// file: verification/rxd_ring_timer_assertions.sv
// Checker for the receive ring block ports
`timescale 1ns/10ps
module rxd_ring_timer_chk
  import rxd_pkg::*;
#(parameter int TICK_CYCLES = RXD_TICK_CYCLES)
(
  // Watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire rxd_reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rx_enable_i,
  input wire logic rx_reset_i,
  input wire logic desc_take_i,
  input wire logic pkt_done_i,
  input wire logic desc_grant_o,
  input wire logic [RXD_IDX_W-1:0] ring_head_o,
  input wire logic ring_empty_o,
  input wire logic flush_o,
  input wire logic rx_timer_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_irq_flush_pair: assert property (flush_o == rx_timer_irq_o)
    else $error("irq and flush differ");
  chk_head_move: assert property ($changed(ring_head_o) |-> desc_grant_o
    || $past(reg_req_i.wr) || $past(rx_reset_i)) else $error("head moved alone");
  chk_size_mask: assert property (reg_req_i.rd && reg_req_i.addr == RXD_OFS_RING_SIZE
    |=> (reg_rdata_o & 32'hFFF0_007F) == 32'h0) else $error("size bits");
  chk_pdly_mask: assert property (reg_req_i.rd && reg_req_i.addr == RXD_OFS_PKT_DELAY
    |=> reg_rdata_o[31:16] == 16'h0) else $error("delay bits");
  chk_force_flush: assert property (reg_req_i.wr && reg_req_i.wdata[31] && !rx_reset_i
    && reg_req_i.addr == RXD_OFS_PKT_DELAY |=> flush_o) else $error("no forced flush");
  chk_empty_hold: assert property (ring_empty_o && !reg_req_i.wr |=> !desc_grant_o)
    else $error("grant while empty");
  chk_off_hold: assert property (!rx_enable_i |=> !desc_grant_o)
    else $error("grant while off");
  chk_rdata_idle: assert property (!reg_req_i.rd |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  chk_rst_quiet: assert property (rx_reset_i |=> !flush_o && ring_head_o == 16'h0)
    else $error("busy after rx reset");
endmodule // rxd_ring_timer_chk
bind rxd_ring_timer rxd_ring_timer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// file: verification/rxd_host_mdl.sv
// Host driver model issuing register cycles
`timescale 1ns/10ps
module rxd_host_mdl
  import rxd_pkg::*;
(
  // Clock and read data
  input wire logic core_clk_i,
  input wire logic [31:0] rdata_i,
  // Register request
  output rxd_reg_req_t req_o
);
  // Host never uses head reads to find finished buffers
  // Host keeps the ring base aligned, base words are outside this block
  // Host uses the delay timers here only to exercise them
  initial req_o = '0;
  // Write cycle, bus scrambled on release
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // Read cycle, data taken the cycle after
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    req_o <= '{addr: a, wdata: 32'h5A5A_5A5A, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_o <= '{addr: ~a, wdata: 32'hA5A5_A5A5, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask
endmodule // rxd_host_mdl

// file: verification/tb_top.sv
// Self-checking bench for the receive ring block
`timescale 1ns/10ps
module tb_top;
  import rxd_pkg::*;
  localparam int TC = 4;
  logic core_clk_i = 0;
  logic rst_i = 1;
  logic en = 0, rxr = 0, take = 0, pkt = 0;
  logic grant, empty, flush, irq;
  logic [15:0] head;
  logic [31:0] rdata, d, v;
  rxd_reg_req_t req;
  int error_cnt = 0, tests_run = 0, mh, mt, mn, g, c;
  logic [15:0] ofs [5] = '{RXD_OFS_RING_SIZE, RXD_OFS_RING_HEAD, RXD_OFS_RING_TAIL,
    RXD_OFS_PKT_DELAY, RXD_OFS_ABS_DELAY};
  logic [31:0] msk [5] = '{32'h000F_FF80, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF};
  always #4 core_clk_i = ~core_clk_i;
  rxd_host_mdl host (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
  rxd_ring_timer #(.TICK_CYCLES(TC)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .rx_enable_i(en), .rx_reset_i(rxr),
    .desc_take_i(take), .pkt_done_i(pkt), .desc_grant_o(grant), .ring_head_o(head),
    .ring_empty_o(empty), .flush_o(flush), .rx_timer_irq_o(irq));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task conclude;
    $display("counts tests=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task pulse_pkt;
    @(posedge core_clk_i) pkt <= 1;
    @(posedge core_clk_i) pkt <= 0;
  endtask
  // Cycles until flush must fall in lo..hi
  task wait_flush(input int lo, input int hi);
    c = 0;
    #1;
    while (flush !== 1'b1 && c <= hi)
    begin
      @(posedge core_clk_i);
      #1 c++;
    end
    chk(c >= lo && c <= hi && irq === 1'b1, 1);
    if (c > hi)
      conclude;
  endtask
  task quiet(input int n);
    repeat (n) begin @(posedge core_clk_i); #1 chk(flush, 0); end
  endtask
  // Take requests each cycle against the ring model
  task takes(input int n);
    g = 0;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge core_clk_i) take <= (i < n);
      #1 chk(grant, g);
      chk(head, mh);
      g = (i < n && en && mh != mt);
      if (g) mh = (mh + 1 >= mn) ? 0 : mh + 1;
    end
  endtask
  initial begin repeat (20000) @(posedge core_clk_i); error_cnt++; conclude; end
  initial
  begin
    void'($urandom(63));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 0;
    foreach (ofs[i]) begin host.rd(ofs[i], d); chk(d, 0); end
    host.rd(16'h2804, d); chk(d, 0);
    chk(empty, 1);
    foreach (ofs[i])
    begin
      d = $urandom;
      host.wr(ofs[i], d);
      #1 if (i == 3) chk(flush, d[31]);
      host.rd(ofs[i], v); chk(v, d & msk[i]);
    end
    $display("test registers done");
    @(posedge core_clk_i) rxr <= 1;
    @(posedge core_clk_i) rxr <= 0;
    host.wr(RXD_OFS_RING_SIZE, 32'h80);
    host.wr(RXD_OFS_RING_HEAD, 0);
    host.wr(RXD_OFS_RING_TAIL, 3);
    mh = 0; mt = 3; mn = 8;
    takes(2);
    @(posedge core_clk_i) en <= 1;
    takes(5);
    chk(empty, 1);
    host.wr(RXD_OFS_RING_TAIL, 1); mt = 1;
    takes(7);
    host.rd(RXD_OFS_RING_HEAD, v); chk(v, mh);
    @(posedge core_clk_i) en <= 0;
    $display("test ring done");
    host.wr(RXD_OFS_ABS_DELAY, 0); host.wr(RXD_OFS_PKT_DELAY, 0);
    pulse_pkt; wait_flush(0, 0);
    host.wr(RXD_OFS_PKT_DELAY, 3);
    pulse_pkt; wait_flush(2 * TC, 3 * TC);
    pulse_pkt; quiet(5); pulse_pkt; wait_flush(2 * TC, 3 * TC);
    host.wr(RXD_OFS_PKT_DELAY, 32'h8000_0000); #1 chk(flush, 1);
    host.rd(RXD_OFS_PKT_DELAY, v); chk(v, 0);
    $display("test packet delay done");
    host.wr(RXD_OFS_PKT_DELAY, 8); host.wr(RXD_OFS_ABS_DELAY, 2);
    pulse_pkt; wait_flush(TC, 2 * TC); quiet(40);
    host.wr(RXD_OFS_PKT_DELAY, 4); host.wr(RXD_OFS_ABS_DELAY, 3);
    fork
      repeat (7) pulse_pkt;
      wait_flush(2 * TC, 3 * TC + 2);
    join
    wait_flush(0, 40);
    host.wr(RXD_OFS_PKT_DELAY, 2); host.wr(RXD_OFS_ABS_DELAY, 8);
    pulse_pkt; wait_flush(TC, 2 * TC); quiet(40);
    host.wr(RXD_OFS_PKT_DELAY, 3);
    pulse_pkt;
    @(posedge core_clk_i) rxr <= 1;
    @(posedge core_clk_i) rxr <= 0;
    quiet(20);
    host.rd(RXD_OFS_PKT_DELAY, v); chk(v, 3);
    $display("test timers done");
    conclude;
  end
endmodule // tb_top
